// File: core/cls_defines.vh
`ifndef CLS_DEFINES_VH
`define CLS_DEFINES_VH

// Byte addresses of the register words
`define CLS_CFG_OFFSET 12'h088
`define CLS_STAT_OFFSET 12'h08c

// Reset value of the settings word
`define CLS_CFG_RESET 32'h00000000

// Settings word field positions
`define CLS_OVM_BIT 30
`define CLS_ACC_MSB 29
`define CLS_ACC_LSB 25
`define CLS_DSEL_BIT 24
`define CLS_DEC_MSB 23
`define CLS_DEC_LSB 19
`define CLS_PWMF_MSB 18
`define CLS_PWMF_LSB 15
`define CLS_PWMM_BIT 14
`define CLS_SPSEL_MSB 13
`define CLS_SPSEL_LSB 12
`define CLS_SPDIV_MSB 11
`define CLS_SPDIV_LSB 8
`define CLS_SPCFG_BIT 7
`define CLS_SPTHR_MSB 6
`define CLS_SPTHR_LSB 4
`define CLS_SURGE_BIT 3
`define CLS_DTC_BIT 2
`define CLS_VLB_BIT 1
`define CLS_BRAKE_BIT 0

// Status word field positions
`define CLS_ST_ACC_LSB 16
`define CLS_ST_ACC_CLAMP_BIT 15
`define CLS_ST_DEC_CLAMP_BIT 14
`define CLS_ST_DEC_LSB 0

// Rate table: highest defined code, rates in 0.1 Hz/s steps
`define CLS_RATE_MAX_CODE 5'h13
`define CLS_RATE_W 14

`endif

// File: core/cls_rate_decode.v
`timescale 1ns/1ps
`include "cls_defines.vh"

module cls_rate_decode (
    input wire [4:0] code,                       // Coded rate
    output reg [`CLS_RATE_W-1:0] rate_tenths,    // Rate in 0.1 Hz/s
    output wire clamped                          // Code above table top
);

    // Table saturates above its top code so a stray code never ramps faster
    assign clamped = (code > `CLS_RATE_MAX_CODE);

    // Coded rate table
    always @* begin
        case (code)
            5'h00: rate_tenths = 14'h0005;
            5'h01: rate_tenths = 14'h000a;
            5'h02: rate_tenths = 14'h0019;
            5'h03: rate_tenths = 14'h0032;
            5'h04: rate_tenths = 14'h004b;
            5'h05: rate_tenths = 14'h0064;
            5'h06: rate_tenths = 14'h00c8;
            5'h07: rate_tenths = 14'h0190;
            5'h08: rate_tenths = 14'h0258;
            5'h09: rate_tenths = 14'h0320;
            5'h0a: rate_tenths = 14'h03e8;
            5'h0b: rate_tenths = 14'h07d0;
            5'h0c: rate_tenths = 14'h0bb8;
            5'h0d: rate_tenths = 14'h0fa0;
            5'h0e: rate_tenths = 14'h1388;
            5'h0f: rate_tenths = 14'h1770;
            5'h10: rate_tenths = 14'h1b58;
            5'h11: rate_tenths = 14'h1f40;
            5'h12: rate_tenths = 14'h2328;
            default: rate_tenths = 14'h2710;
        endcase
    end

endmodule

// File: core/cls_settings_regs.v
`timescale 1ns/1ps
`include "cls_defines.vh"

// How it works
// - Settings word at 0x88, resets to zero
// - Bit 30 turns overdrive modulation on
// - Bits 29-25 pick coded acceleration rate
// - Bit 24 picks deceleration rate source
// - All bits read/write, reset zero

module cls_settings_regs #(
    parameter ADDR_W = 12                         // APB address width
) (
    input wire core_clk,                          // Core clock, 125 MHz
    input wire resetn,                            // Sync reset, active low
    input wire psel,                              // APB select
    input wire penable,                           // APB access phase
    input wire pwrite,                            // APB write
    input wire [ADDR_W-1:0] paddr,                // APB byte address
    input wire [31:0] pwdata,                     // APB write data
    input wire [3:0] pstrb,                       // APB byte strobes
    output reg [31:0] prdata,                     // APB read data
    output wire pready,                           // APB ready
    output wire pslverr,                          // APB error
    output wire overdrive_modulation_en,          // Overdrive modulation on
    output wire [4:0] loop_accel_rate,            // Acceleration code
    output wire decel_source_sel,                 // Decel from accel field
    output wire [4:0] loop_decel_rate,            // Deceleration code
    output wire [3:0] pwm_out_freq,               // Output PWM frequency
    output wire pwm_mode,                         // PWM mode
    output wire [1:0] speed_pulse_select,         // Speed feedback select
    output wire [3:0] speed_pulse_divider,        // Speed feedback divider
    output wire speed_pulse_config,               // Speed feedback config
    output wire [2:0] speed_pulse_emf_threshold,  // Back-EMF threshold
    output wire surge_guard_en,                   // Surge protection on
    output wire dead_gap_correction_en,           // Dead-time correction on
    output wire velocity_loop_bypass,             // Speed loop bypassed
    output wire slow_recirculation_brake_en,      // Low-speed brake on
    output reg [4:0] eff_decel_code,              // Decel code in force
    output reg [`CLS_RATE_W-1:0] accel_rate,      // Accel rate, 0.1 Hz/s
    output reg [`CLS_RATE_W-1:0] decel_rate       // Decel rate, 0.1 Hz/s
);

    ////////////////////////////////////////////////////////////////////////
    // Settings storage

    reg [31:0] cfg;
    reg err_q;
    reg accel_clamp;
    reg decel_clamp;
    wire [31:0] next_cfg;
    wire setup_phase;
    wire access_phase;
    wire hit_cfg;
    wire hit_stat;
    wire bad_req;
    wire cfg_write;
    wire [4:0] next_eff_decel;
    wire [`CLS_RATE_W-1:0] accel_lut;
    wire [`CLS_RATE_W-1:0] decel_lut;
    wire accel_lut_clamp;
    wire decel_lut_clamp;
    wire [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // APB phase and address decode

    // Setup and access phases of a transfer
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;

    // Full address compare, so unaligned or stray addresses miss
    assign hit_cfg = (paddr == `CLS_CFG_OFFSET);
    assign hit_stat = (paddr == `CLS_STAT_OFFSET);

    // Unmapped address, or a write to the read-only status word
    assign bad_req = ~(hit_cfg | hit_stat) | (hit_stat & pwrite);

    // Answer in the first access cycle, no wait states
    assign pready = access_phase;

    // Error flag judged at setup, shown only while ready is high
    assign pslverr = access_phase & err_q;

    // Write lands at the access edge and only when legal
    assign cfg_write = access_phase & pwrite & hit_cfg & ~err_q;

    // Capture the error verdict at the setup edge
    always @(posedge core_clk) begin
        if (!resetn) begin
            err_q <= 1'b0;
        end else if (setup_phase) begin
            err_q <= bad_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte-lane write merge

    // Each lane follows its strobe, so partial writes keep other fields
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign next_cfg[lane*8 +: 8] = (cfg_write && pstrb[lane])
                ? pwdata[lane*8 +: 8] : cfg[lane*8 +: 8];
        end
    endgenerate

    // Whole word, reserved top bit too, is stored and reset to zero
    always @(posedge core_clk) begin
        if (!resetn) begin
            cfg <= `CLS_CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field outputs straight from the stored word

    // Modulation beyond the linear range
    assign overdrive_modulation_en = cfg[`CLS_OVM_BIT];

    // Ramp rate codes and the decel source choice
    assign loop_accel_rate = cfg[`CLS_ACC_MSB:`CLS_ACC_LSB];
    assign decel_source_sel = cfg[`CLS_DSEL_BIT];
    assign loop_decel_rate = cfg[`CLS_DEC_MSB:`CLS_DEC_LSB];

    // PWM output settings
    assign pwm_out_freq = cfg[`CLS_PWMF_MSB:`CLS_PWMF_LSB];
    assign pwm_mode = cfg[`CLS_PWMM_BIT];

    // Speed feedback signal options
    assign speed_pulse_select = cfg[`CLS_SPSEL_MSB:`CLS_SPSEL_LSB];
    assign speed_pulse_divider = cfg[`CLS_SPDIV_MSB:`CLS_SPDIV_LSB];
    assign speed_pulse_config = cfg[`CLS_SPCFG_BIT];
    assign speed_pulse_emf_threshold = cfg[`CLS_SPTHR_MSB:`CLS_SPTHR_LSB];

    // Protection and loop options
    assign surge_guard_en = cfg[`CLS_SURGE_BIT];
    assign dead_gap_correction_en = cfg[`CLS_DTC_BIT];
    assign velocity_loop_bypass = cfg[`CLS_VLB_BIT];
    assign slow_recirculation_brake_en = cfg[`CLS_BRAKE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Ramp rate resolution

    // Decel follows the accel code when the source bit is set
    assign next_eff_decel = cfg[`CLS_DSEL_BIT]
        ? cfg[`CLS_ACC_MSB:`CLS_ACC_LSB]
        : cfg[`CLS_DEC_MSB:`CLS_DEC_LSB];

    // Acceleration table lookup
    cls_rate_decode u_accel_decode (
        .code(cfg[`CLS_ACC_MSB:`CLS_ACC_LSB]),
        .rate_tenths(accel_lut),
        .clamped(accel_lut_clamp)
    );

    // Deceleration lookup uses the same coded table
    cls_rate_decode u_decel_decode (
        .code(next_eff_decel),
        .rate_tenths(decel_lut),
        .clamped(decel_lut_clamp)
    );

    // Registered so the ramp logic sees clean, glitch-free rates;
    // costs one cycle of lag after a write, harmless for ramp settings
    always @(posedge core_clk) begin
        if (!resetn) begin
            eff_decel_code <= 5'h00;
            accel_rate <= 14'h0005;
            decel_rate <= 14'h0005;
            accel_clamp <= 1'b0;
            decel_clamp <= 1'b0;
        end else begin
            eff_decel_code <= next_eff_decel;
            accel_rate <= accel_lut;
            decel_rate <= decel_lut;
            accel_clamp <= accel_lut_clamp;
            decel_clamp <= decel_lut_clamp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word and read data

    // Shows the rates actually in force and any saturated code
    assign status_word = {2'b00, accel_rate, accel_clamp, decel_clamp, decel_rate};

    // Read data is loaded at setup and held through the access phase;
    // misses and writes read as zero
    always @(posedge core_clk) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (setup_phase) begin
            if (!pwrite && hit_cfg) begin
                prdata <= cfg;
            end else if (!pwrite && hit_stat) begin
                prdata <= status_word;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

endmodule

// File: tb/cls_settings_props.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module cls_settings_props #(
    parameter ADDR_W = 12
) (
    input wire core_clk, resetn, psel, penable, pwrite, pready, pslverr,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire [3:0] pstrb, pwm_out_freq, speed_pulse_divider,
    input wire overdrive_modulation_en, decel_source_sel, pwm_mode, speed_pulse_config,
    input wire surge_guard_en, dead_gap_correction_en, velocity_loop_bypass,
    input wire slow_recirculation_brake_en,
    input wire [4:0] loop_accel_rate, loop_decel_rate, eff_decel_code,
    input wire [1:0] speed_pulse_select,
    input wire [2:0] speed_pulse_emf_threshold,
    input wire [13:0] accel_rate, decel_rate
);
    // Field outputs put back in register order, reserved bit left out
    wire [30:0] cfg_view = {overdrive_modulation_en, loop_accel_rate, decel_source_sel,
        loop_decel_rate, pwm_out_freq, pwm_mode, speed_pulse_select, speed_pulse_divider,
        speed_pulse_config, speed_pulse_emf_threshold, surge_guard_en,
        dead_gap_correction_en, velocity_loop_bypass, slow_recirculation_brake_en};
    wire [30:0] wlow = pwdata[30:0];
    wire [4:0] pick = decel_source_sel ? loop_accel_rate : loop_decel_rate;
    wire acc = psel && penable;
    wire hit = paddr == 12'h088;
    wire ovm_wr = acc && pwrite && hit && pstrb[3];

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    ready_follows_a: assert property (pready == acc) else $error("pready not psel and penable");
    reset_clear_a: assert property ($rose(resetn) |-> cfg_view == 31'h0 && prdata == 32'h0)
        else $error("settings not zero after reset");
    full_write_a: assert property (acc && pwrite && hit && pstrb == 4'hf |=>
        cfg_view == $past(wlow)) else $error("fields differ from written word");
    read_match_a: assert property (acc && !pwrite && hit |->
        prdata[30:0] == cfg_view && !pslverr) else $error("read word differs from fields");
    ovm_hold_a: assert property ($past(resetn) && overdrive_modulation_en !=
        $past(overdrive_modulation_en) |-> $past(ovm_wr)) else $error("overdrive moved alone");
    accel_top_a: assert property (loop_accel_rate == 5'h13 |=> accel_rate == 14'h2710)
        else $error("top accel code rate wrong");
    decel_pick_a: assert property ($past(resetn) |-> eff_decel_code == $past(pick))
        else $error("decel code source wrong");
    bad_addr_a: assert property (acc && paddr != 12'h088 && paddr != 12'h08c |-> pslverr)
        else $error("unmapped access not refused");
    stat_write_a: assert property (acc && pwrite && paddr == 12'h08c |-> pslverr)
        else $error("status write not refused");
endmodule

bind cls_settings_regs cls_settings_props #(.ADDR_W(ADDR_W)) u_props (.*);

// File: tb/cls_settings_regs_test.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module cls_settings_regs_test;
    reg core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [3:0] pstrb = 4'h0;
    wire [31:0] prdata;
    wire pready, pslverr, overdrive_modulation_en, decel_source_sel, pwm_mode;
    wire speed_pulse_config, surge_guard_en, dead_gap_correction_en, velocity_loop_bypass;
    wire slow_recirculation_brake_en;
    wire [4:0] loop_accel_rate, loop_decel_rate, eff_decel_code;
    wire [3:0] pwm_out_freq, speed_pulse_divider;
    wire [1:0] speed_pulse_select;
    wire [2:0] speed_pulse_emf_threshold;
    wire [13:0] accel_rate, decel_rate;
    wire [30:0] fields = {overdrive_modulation_en, loop_accel_rate, decel_source_sel,
        loop_decel_rate, pwm_out_freq, pwm_mode, speed_pulse_select, speed_pulse_divider,
        speed_pulse_config, speed_pulse_emf_threshold, surge_guard_en,
        dead_gap_correction_en, velocity_loop_bypass, slow_recirculation_brake_en};
    integer failures = 0, num_checks = 0, cycles = 0, i;
    reg [31:0] rd;
    reg err;
    reg [4:0] codes [0:4];
    reg [13:0] rates [0:4];

    cls_settings_regs dut (.*);

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    // Hang guard, far above the hundred or so cycles the tests need
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures = failures + 1;
            end_sim;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task check(input string what, input [31:0] seen, input [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; waits on pready rather than assuming zero wait states
    task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Derived rates lag the word by one edge; wait two edges and step off the edge to sample
    task settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        codes[0] = 5'h00; codes[1] = 5'h01; codes[2] = 5'h02; codes[3] = 5'h0a; codes[4] = 5'h13;
        rates[0] = 14'h0005; rates[1] = 14'h000a; rates[2] = 14'h0019;
        rates[3] = 14'h03e8; rates[4] = 14'h2710;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        apb(1'b0, 12'h088, 32'h0, 4'h0);
        check("reset word", rd, 32'h0);
        check("reset accel rate", accel_rate, 32'h5);
        apb(1'b1, 12'h088, 32'hffffffff, 4'hf);
        apb(1'b0, 12'h088, 32'h0, 4'h0);
        check("all ones word", rd, 32'hffffffff);
        check("all ones fields", fields, 32'h7fffffff);
        apb(1'b1, 12'h088, 32'h40000000, 4'hf);
        settle;
        check("overdrive alone", fields, 32'h40000000);
        apb(1'b1, 12'h088, 32'h12345678, 4'hf);
        apb(1'b1, 12'h088, 32'h000000ff, 4'h1);
        settle;
        check("pattern fields", fields, 32'h123456ff);
        apb(1'b1, 12'h090, 32'h0, 4'hf);
        check("unmapped error", err, 32'h1);
        apb(1'b0, 12'h088, 32'h0, 4'h0);
        check("word kept", rd, 32'h123456ff);
        // Accel code table at its corners
        for (i = 0; i < 5; i = i + 1) begin
            apb(1'b1, 12'h088, {2'b00, codes[i], 25'h0}, 4'hf);
            settle;
            check("accel rate", accel_rate, rates[i]);
        end
        apb(1'b1, 12'h088, 32'h04280000, 4'hf);
        settle;
        check("own decel code", eff_decel_code, 32'h5);
        check("own decel rate", decel_rate, 32'h64);
        apb(1'b1, 12'h088, 32'h05280000, 4'hf);
        settle;
        check("shared decel code", eff_decel_code, 32'h2);
        check("shared decel rate", decel_rate, 32'h19);
        // Codes above the table top saturate and raise both clamp bits
        apb(1'b1, 12'h088, 32'h3ea00000, 4'hf);
        settle;
        apb(1'b0, 12'h08c, 32'h0, 4'h0);
        check("status read error", err, 32'h0);
        check("clamped status", rd, 32'h2710e710);
        apb(1'b1, 12'h08c, 32'hffffffff, 4'hf);
        check("status write error", err, 32'h1);
        apb(1'b1, 12'h088, 32'hffffffff, 4'h0);
        apb(1'b0, 12'h088, 32'h0, 4'h0);
        check("no strobe write", rd, 32'h3ea00000);
        // Reset in mid-run clears the word and returns the derived rates to the code 0 rate
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        apb(1'b0, 12'h088, 32'h0, 4'h0);
        check("mid-run reset word", rd, 32'h0);
        check("mid-run reset fields", fields, 32'h0);
        check("mid-run reset decel", decel_rate, 32'h5);
        end_sim;
    end
endmodule
